// >>> include/audio_rx_pkg.sv
// package: register map, field layout and codes of the receiver control bank
package audio_rx_pkg;
  // register offsets
  localparam logic [7:0] ADDR_WORD_SHORTEN_ENABLE      = 8'h00;
  localparam logic [7:0] ADDR_CLK_HOLD   = 8'h01;
  localparam logic [7:0] ADDR_DEEMPH     = 8'h02;
  localparam logic [7:0] ADDR_OUT_SRC    = 8'h03;
  localparam logic [7:0] ADDR_RUN_INPUT  = 8'h04;
  localparam logic [7:0] ADDR_SER_FMT    = 8'h05;
  localparam logic [7:0] ADDR_ERR_EN     = 8'h06;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h07;
  localparam logic [7:0] ADDR_IMODE_HI   = 8'h08;
  localparam logic [7:0] ADDR_IMODE_LO   = 8'h09;
  localparam logic [7:0] ADDR_CHAN_STAT  = 8'h0A;
  localparam logic [7:0] ADDR_RX_ERR     = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h0D;
  // reset values
  localparam logic [7:0] REG_RESET      = 8'h00;
  // writable bits of the word shorten enable and seven-bit registers
  localparam logic [7:0] WORD_SHORTEN_ENABLE_WMASK     = 8'h04;
  localparam logic [7:0] SEVEN_WMASK     = 8'h7F;
  // field positions
  localparam int WORD_SHORTEN_ENABLE_BIT   = 2;
  localparam int SWCLK_BIT   = 7;
  localparam int MUTE_BIT    = 6;
  localparam int INT_POL_LSB = 4;
  localparam int HOLD_LSB    = 2;
  localparam int RECOVERED_CLOCK_RATE_BIT   = 1;
  localparam int CHS_BIT     = 0;
  localparam int INHIBIT_BIT = 7;
  localparam int DEEMPH_LSB  = 4;
  localparam int RUN_BIT     = 7;
  localparam int RXD_BIT     = 6;
  localparam int RXSEL_LSB   = 3;
  localparam int TXSEL_LSB   = 0;
  localparam int AUX_LSB     = 4;
  // error bits that may touch the sample (crc bits 6 and 5 never do)
  localparam logic [6:0] ERR_HOLD_BITS  = 7'h1F;
  localparam int         IRQ_RECEIVER_FAULT_EVENT_BIT   = 2;
  // audio path
  localparam int         SAMPLE_W       = 24;
  localparam int         FIFO_DEPTH     = 4;
  localparam logic [3:0] AUX_MAX        = 4'h8;
  localparam logic [4:0] RES20_DROP     = 5'h04;
  localparam logic [4:0] RES16_DROP     = 5'h08;
  // codes
  typedef enum logic [1:0] {HOLD_LAST = 2'h0, HOLD_ZERO = 2'h1, HOLD_PASS = 2'h2} hold_e;
  typedef enum logic [1:0] {POL_HIGH = 2'h0, POL_LOW = 2'h1, POL_OPEN = 2'h2} int_pol_e;
  typedef enum logic [1:0] {MODE_RISE = 2'h0, MODE_FALL = 2'h1, MODE_LEVEL = 2'h2} imode_e;
  typedef enum logic [1:0] {COEF_OFF = 2'h0, COEF_32K = 2'h1, COEF_44K = 2'h2,
                            COEF_48K = 2'h3} coef_e;
  localparam logic [2:0] DEEMPH_AUTO    = 3'h4;
  localparam logic [1:0] RES_24         = 2'h0;
  localparam logic [1:0] RES_20         = 2'h1;
  localparam logic [1:0] RES_16         = 2'h2;
  localparam logic [1:0] RES_RAW        = 2'h3;
  // serial output format register layout
  typedef struct packed {
    logic       master;
    logic       bclk_128;
    logic [1:0] resolution;
    logic       justify;
    logic       msb_delay;
    logic       bclk_pol;
    logic       wclk_pol;
  } ser_fmt_s;
endpackage

// >>> verilog/audio_receiver_control_regs.sv
// receiver control register bank, its sample path and a small sample fifo
// Functional notes
// - truncate to 24 minus aux when deemphasis on
// - system clock drives outputs on lock loss
// - mute zeroes serial output samples
// - receive error hold: last, zero, unchanged
// - interrupt pin: high, low, open drain
// - channel status decoded from chosen channel
// - inhibit blocks channel status buffer update
// - deemphasis select picks fixed coefficients
// - auto deemphasis from channel A, nonlinear off
// - run low stops path, port stays usable
// - recovered master clock tristate control
// - input selects pick one of eight
// - master or slave, bit clock rate
// - resolution 24, 20 or 16 bits
// - resolution 11 gives raw copy, left
// - right justify only master, not raw
// - msb delay one or two bit periods
// - bit and word clock polarity controls
// - error enables gate register, pin, hold
// - interrupt enables gate status and line
// - per source rise, fall or level mode
// - error register read clears unless active
// - status read clears unless level active
`timescale 1ns/1ns
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PW = $clog2(DEPTH);
  // full level needs the extra count bit, a pointer-wide cast would wrap it to zero
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];     // storage words
  logic [PW-1:0]    wr_ptr_r;        // next slot to fill
  logic [PW-1:0]    rd_ptr_r;        // oldest word
  logic [PW:0]      count_r;         // words held
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (count_r != FULL_COUNT) && !i_flush;
  assign o_out_valid = (count_r != '0) && !i_flush;
  assign o_out_data  = mem[rd_ptr_r];

  // storage write, no reset needed on data
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || i_flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + PW'(push);
      rd_ptr_r <= rd_ptr_r + PW'(pop);
      count_r  <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module audio_receiver_control_regs (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_sys_rst,
  // control port, same clock
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [7:0]            i_reg_wdata,
  output logic [7:0]                 o_reg_rdata,
  // receiver state, same clock
  input  wire logic                  i_lock_lost,
  input  wire logic [6:0]            i_err_cond,
  input  wire logic [6:0]            i_irq_cond,
  input  wire logic [7:0]            i_chan_a_status,
  input  wire logic [7:0]            i_chan_b_status,
  input  wire logic [1:0]            i_chan_a_rate,
  input  wire logic                  i_nonlinear,
  input  wire logic                  i_buf_xfer_req,
  // received samples
  input  wire logic                  i_smp_valid,
  output logic                       o_smp_ready,
  input  wire logic [23:0]           i_smp_data,
  input  wire logic                  i_smp_raw_blk,
  output logic                       o_out_valid,
  input  wire logic                  i_out_ready,
  output logic [23:0]                o_out_data,
  // steering outputs
  output logic                       o_run,
  output logic                       o_clk_from_system,
  output logic                       o_recovered_master_clock_half_rate,
  output logic                       o_recovered_master_clock_oe_n,
  output logic [2:0]                 o_receiver_input_select,
  output logic [2:0]                 o_passthrough_input_select,
  output logic [1:0]                 o_deemph_coef,
  output logic                       o_buf_xfer_en,
  output audio_rx_pkg::ser_fmt_s     o_ser_fmt,
  output logic                       o_rx_err_pin,
  output logic                       o_int_out,
  output logic                       o_int_oe_n
);
  localparam int SAMPLE_W_L = audio_rx_pkg::SAMPLE_W;      // sample width for local declarations
  localparam int IRQ_B      = audio_rx_pkg::IRQ_RECEIVER_FAULT_EVENT_BIT;  // error summary slot among sources
  // control registers
  logic [7:0] word_shorten_enable_r, clk_hold_r, deemph_r, out_src_r, run_in_r, fmt_r;
  logic [6:0] err_en_r, irq_en_r, imode_hi_r, imode_lo_r;
  // status and history
  logic [6:0] rx_err_r;          // sticky receiver errors
  logic [6:0] irq_stat_r;        // sticky interrupt status
  logic [6:0] irq_prev_r;        // source value one cycle ago
  logic [SAMPLE_W_L-1:0] last_smp_r;  // last good sample for hold
  logic [7:0] rdata_nxt;

  // drop the low n bits of a sample
  function automatic logic [SAMPLE_W_L-1:0] keep_top(input logic [4:0] drop);
    logic [SAMPLE_W_L-1:0] m;
    m = '1;
    m = m << drop;
    return m;
  endfunction

  // address compare shared by writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // decoded fields
  wire        run         = run_in_r[audio_rx_pkg::RUN_BIT];
  wire        mute        = clk_hold_r[audio_rx_pkg::MUTE_BIT];
  wire [1:0]  hold_code   = clk_hold_r[audio_rx_pkg::HOLD_LSB +: 2];
  wire [1:0]  pol_code    = clk_hold_r[audio_rx_pkg::INT_POL_LSB +: 2];
  wire        status_channel_pick         = clk_hold_r[audio_rx_pkg::CHS_BIT];
  wire [2:0]  deemph_sel  = deemph_r[audio_rx_pkg::DEEMPH_LSB +: 3];
  wire        rd_err      = i_reg_rd && hit(i_reg_addr, audio_rx_pkg::ADDR_RX_ERR);
  wire        rd_irq      = i_reg_rd && hit(i_reg_addr, audio_rx_pkg::ADDR_IRQ_STAT);

  // writes: the ten control registers, status registers are read only; only the word shorten enable and seven-bit registers drop their unused bits
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      word_shorten_enable_r    <= audio_rx_pkg::REG_RESET;
      clk_hold_r <= audio_rx_pkg::REG_RESET;
      deemph_r   <= audio_rx_pkg::REG_RESET;
      out_src_r  <= audio_rx_pkg::REG_RESET;
      run_in_r   <= audio_rx_pkg::REG_RESET;
      fmt_r      <= audio_rx_pkg::REG_RESET;
      err_en_r   <= '0;
      irq_en_r   <= '0;
      imode_hi_r <= '0;
      imode_lo_r <= '0;
    end else if (i_reg_wr) begin
      // port stays writable while run is low
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_WORD_SHORTEN_ENABLE))     word_shorten_enable_r    <= i_reg_wdata & audio_rx_pkg::WORD_SHORTEN_ENABLE_WMASK;
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_CLK_HOLD))  clk_hold_r <= i_reg_wdata;
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_DEEMPH))    deemph_r   <= i_reg_wdata;
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_OUT_SRC))   out_src_r  <= i_reg_wdata;
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_RUN_INPUT)) run_in_r   <= i_reg_wdata;
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_SER_FMT))   fmt_r      <= i_reg_wdata;
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_ERR_EN))    err_en_r   <= i_reg_wdata[6:0];
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_IRQ_EN))    irq_en_r   <= i_reg_wdata[6:0];
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_IMODE_HI))  imode_hi_r <= i_reg_wdata[6:0];
      if (hit(i_reg_addr, audio_rx_pkg::ADDR_IMODE_LO))  imode_lo_r <= i_reg_wdata[6:0];
    end
  end

  // clocks and muxes
  assign o_run             = run;
  assign o_clk_from_system = clk_hold_r[audio_rx_pkg::SWCLK_BIT] && i_lock_lost;
  assign o_recovered_master_clock_half_rate  = clk_hold_r[audio_rx_pkg::RECOVERED_CLOCK_RATE_BIT];
  assign o_recovered_master_clock_oe_n       = run_in_r[audio_rx_pkg::RXD_BIT];
  assign o_receiver_input_select    = run_in_r[audio_rx_pkg::RXSEL_LSB +: 3];
  assign o_passthrough_input_select = run_in_r[audio_rx_pkg::TXSEL_LSB +: 3];
  assign o_buf_xfer_en     = run && i_buf_xfer_req && !deemph_r[audio_rx_pkg::INHIBIT_BIT];

  // output format: raw mode forces left, right only as master
  wire       raw_mode = fmt_r[5:4] == audio_rx_pkg::RES_RAW;
  wire       just_ok  = fmt_r[3] && fmt_r[7] && !raw_mode;
  assign o_ser_fmt = '{master: fmt_r[7], bclk_128: fmt_r[6], resolution: fmt_r[5:4],
                       justify: just_ok, msb_delay: fmt_r[2] && !just_ok,
                       bclk_pol: fmt_r[1], wclk_pol: fmt_r[0]};

  // deemphasis: fixed codes, or auto from channel A status
  wire        a_emph    = !i_chan_a_status[0];   // bit low means pre-emphasis present
  wire [1:0]  auto_coef = (a_emph && !i_nonlinear && i_chan_a_rate != audio_rx_pkg::COEF_OFF)
                          ? i_chan_a_rate : audio_rx_pkg::COEF_OFF;
  assign o_deemph_coef = (deemph_sel == audio_rx_pkg::DEEMPH_AUTO) ? auto_coef
                       : (deemph_sel[2] ? audio_rx_pkg::COEF_OFF : deemph_sel[1:0]);

  // truncation only matters once the filter is in use
  wire [3:0]  aux_raw   = i_chan_a_status[audio_rx_pkg::AUX_LSB +: 4];
  wire [3:0]  aux_width = (aux_raw > audio_rx_pkg::AUX_MAX) ? 4'h0 : aux_raw;
  wire        word_shorten_enable_on  = word_shorten_enable_r[audio_rx_pkg::WORD_SHORTEN_ENABLE_BIT] && (o_deemph_coef != audio_rx_pkg::COEF_OFF);
  wire [23:0] smp_word_shorten_enable = word_shorten_enable_on ? (i_smp_data & keep_top({1'b0, aux_width}))
                                   : i_smp_data;

  // receive errors gated by enables; crc bits never touch samples
  wire [6:0]  err_live  = i_err_cond & err_en_r;
  wire        err_hold  = |(err_live & audio_rx_pkg::ERR_HOLD_BITS);
  wire [23:0] smp_held  = !err_hold                         ? smp_word_shorten_enable
                        : (hold_code == audio_rx_pkg::HOLD_ZERO) ? 24'h000000
                        : (hold_code == audio_rx_pkg::HOLD_PASS) ? smp_word_shorten_enable
                        : last_smp_r;

  // resolution, raw copy and mute
  wire [23:0] smp_res   = (fmt_r[5:4] == audio_rx_pkg::RES_20) ? smp_held & keep_top(audio_rx_pkg::RES20_DROP)
                        : (fmt_r[5:4] == audio_rx_pkg::RES_16) ? smp_held & keep_top(audio_rx_pkg::RES16_DROP)
                        : smp_held;
  wire [23:0] smp_fmt   = raw_mode ? {i_smp_data[23:1], i_smp_raw_blk} : smp_res;
  wire [23:0] fifo_in   = mute ? 24'h000000 : smp_fmt;
  wire        fifo_push;
  wire        fifo_in_ready;

  assign fifo_push   = i_smp_valid && run;
  assign o_smp_ready = fifo_in_ready;

  // remember the last sample that went out unaltered
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !run) begin
      last_smp_r <= '0;
    end else if (fifo_push && fifo_in_ready && !err_hold) begin
      last_smp_r <= smp_word_shorten_enable;
    end
  end

  // four words absorb bursts; a stalled drain backs up to the receiver
  sample_fifo #(.WIDTH(audio_rx_pkg::SAMPLE_W), .DEPTH(audio_rx_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_sys_rst   (i_sys_rst),
    .i_flush     (!run),
    .i_in_valid  (fifo_push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in),
    .o_out_valid (o_out_valid),
    .i_out_ready (i_out_ready),
    .o_out_data  (o_out_data)
  );

  // interrupt events per source mode; reserved mode acts as rising
  wire [6:0] mode_fall  = imode_lo_r & ~imode_hi_r;
  wire [6:0] mode_level = imode_hi_r & ~imode_lo_r;
  wire [6:0] mode_rise  = ~(mode_fall | mode_level);
  wire [6:0] irq_src    = {i_irq_cond[6:3], i_irq_cond[IRQ_B] | (|err_live), i_irq_cond[1:0]};
  wire [6:0] irq_evt    = ((mode_rise & irq_src & ~irq_prev_r)
                        | (mode_fall & ~irq_src & irq_prev_r)
                        | (mode_level & irq_src)) & irq_en_r;

  // sticky bits: set beats a read clear in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !run) begin
      rx_err_r   <= '0;
      irq_stat_r <= '0;
      irq_prev_r <= '0;
    end else begin
      irq_prev_r <= irq_src;
      rx_err_r   <= (rd_err ? 7'h00 : rx_err_r & err_en_r) | err_live;
      irq_stat_r <= (rd_irq ? 7'h00 : irq_stat_r & irq_en_r) | irq_evt;
    end
  end

  // interrupt pin; open drain only pulls low
  wire irq_line = |irq_stat_r;
  assign o_rx_err_pin = |rx_err_r;
  assign o_int_out    = (pol_code == audio_rx_pkg::POL_LOW || pol_code == audio_rx_pkg::POL_OPEN)
                        ? !irq_line : irq_line;
  assign o_int_oe_n   = (pol_code == audio_rx_pkg::POL_OPEN) && !irq_line;

  // read mux, status register follows the chosen channel
  always_comb begin
    case (i_reg_addr)
      audio_rx_pkg::ADDR_WORD_SHORTEN_ENABLE:     rdata_nxt = word_shorten_enable_r;
      audio_rx_pkg::ADDR_CLK_HOLD:  rdata_nxt = clk_hold_r;
      audio_rx_pkg::ADDR_DEEMPH:    rdata_nxt = deemph_r;
      audio_rx_pkg::ADDR_OUT_SRC:   rdata_nxt = out_src_r;
      audio_rx_pkg::ADDR_RUN_INPUT: rdata_nxt = run_in_r;
      audio_rx_pkg::ADDR_SER_FMT:   rdata_nxt = fmt_r;
      audio_rx_pkg::ADDR_ERR_EN:    rdata_nxt = {1'b0, err_en_r};
      audio_rx_pkg::ADDR_IRQ_EN:    rdata_nxt = {1'b0, irq_en_r};
      audio_rx_pkg::ADDR_IMODE_HI:  rdata_nxt = {1'b0, imode_hi_r};
      audio_rx_pkg::ADDR_IMODE_LO:  rdata_nxt = {1'b0, imode_lo_r};
      audio_rx_pkg::ADDR_CHAN_STAT: rdata_nxt = status_channel_pick ? i_chan_b_status : i_chan_a_status;
      audio_rx_pkg::ADDR_RX_ERR:    rdata_nxt = {1'b0, rx_err_r};
      audio_rx_pkg::ADDR_IRQ_STAT:  rdata_nxt = {1'b0, irq_stat_r};
      default:                      rdata_nxt = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_nxt;
    end
  end

  // checks
  a_mute_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (mute && fifo_push) |-> fifo_in == 24'h000000) else $error("muted sample not zero");
  a_hold_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (err_hold && !raw_mode && hold_code == audio_rx_pkg::HOLD_ZERO) |-> fifo_in == 24'h000000)
    else $error("hold zero failed");
  a_int_low_pol: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (pol_code == audio_rx_pkg::POL_LOW) |-> (o_int_out == !(|irq_stat_r) && !o_int_oe_n))
    else $error("active low pin wrong");
  a_chan_pick: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_reg_rd && i_reg_addr == audio_rx_pkg::ADDR_CHAN_STAT && status_channel_pick)
    |=> o_reg_rdata == $past(i_chan_b_status)) else $error("channel b not chosen");
  a_run_flush: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !run |=> !o_out_valid) else $error("output live while stopped");
  a_err_read_clr: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (rd_err && run) |=> rx_err_r == $past(err_live)) else $error("error read clear wrong");
  a_irq_mask_block: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (irq_stat_r == 7'h00 && irq_en_r == 7'h00 && !i_reg_wr) |=> irq_stat_r == 7'h00)
    else $error("masked source set status");
  a_rise_sets: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (run && irq_en_r[0] && mode_rise[0] && irq_src[0] && !irq_prev_r[0])
    |=> irq_stat_r[0] ##1 (irq_stat_r[0] || $past(rd_irq))) else $error("rising event lost");
  a_level_holds: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (run && rd_irq && irq_en_r[1] && mode_level[1] && irq_src[1]) |=> irq_stat_r[1])
    else $error("level status cleared");
  a_recovered_master_clock_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(run_in_r[audio_rx_pkg::RXD_BIT]) |-> o_recovered_master_clock_oe_n) else $error("recovered_master_clock still driven");
endmodule

`default_nettype wire

// >>> testbench/sample_sink.sv
// sample sink at the fifo output: takes words and stalls at random
`timescale 1ns/1ns
`default_nettype none
module sample_sink (
  input  wire logic        i_clk_sys,
  input  wire logic        i_hold,
  input  wire logic        i_valid,
  input  wire logic [23:0] i_data,
  output logic             o_ready,
  output logic             o_got,
  output logic [23:0]      o_word
);
  initial o_ready = 1'b0;
  // ready drops now and then so the fifo sees back pressure; hold stalls it fully
  always @(negedge i_clk_sys) o_ready <= !i_hold && ($urandom % 3 != 0);
  // a word counts as taken only at an edge where valid and ready meet
  always @(posedge i_clk_sys) begin
    o_got  <= i_valid && o_ready;
    o_word <= i_data;
  end
endmodule
`default_nettype wire

// >>> testbench/audio_receiver_control_regs_test.sv
// bench: drives the receiver control bank, models it and compares
`timescale 1ns/1ns
`default_nettype none
module audio_receiver_control_regs_test;
  logic        i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic        i_lock_lost = 1'b0, i_nonlinear = 1'b0, i_buf_xfer_req = 1'b0;
  logic        i_smp_valid = 1'b0, i_smp_raw_blk = 1'b0, hold = 1'b1;
  logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_chan_a_status = 8'h30;
  logic [7:0]  i_chan_b_status = 8'hA5, o_reg_rdata, f;
  logic [6:0]  i_err_cond = 7'h00, i_irq_cond = 7'h00;
  logic [1:0]  i_chan_a_rate = 2'h2, o_deemph_coef;
  logic [23:0] i_smp_data = 24'h000000, o_out_data, word, e;
  logic [2:0]  o_receiver_input_select, o_passthrough_input_select;
  logic        o_smp_ready, o_out_valid, i_out_ready, o_run, o_clk_from_system, got;
  logic        o_recovered_master_clock_half_rate, o_recovered_master_clock_oe_n, o_buf_xfer_en, o_rx_err_pin;
  logic        o_int_out, o_int_oe_n;
  audio_rx_pkg::ser_fmt_s o_ser_fmt;
  logic [23:0] expq[$];
  int          fail_count = 0, samples_checked = 0, cyc = 0, v;
  audio_receiver_control_regs dut (.i_clk_sys, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd,
    .i_reg_wdata, .o_reg_rdata, .i_lock_lost, .i_err_cond, .i_irq_cond, .i_chan_a_status,
    .i_chan_b_status, .i_chan_a_rate, .i_nonlinear, .i_buf_xfer_req, .i_smp_valid,
    .o_smp_ready, .i_smp_data, .i_smp_raw_blk, .o_out_valid, .i_out_ready, .o_out_data,
    .o_run, .o_clk_from_system, .o_recovered_master_clock_half_rate, .o_recovered_master_clock_oe_n, .o_receiver_input_select,
    .o_passthrough_input_select, .o_deemph_coef, .o_buf_xfer_en, .o_ser_fmt, .o_rx_err_pin,
    .o_int_out, .o_int_oe_n);
  sample_sink sink (.i_clk_sys, .i_hold(hold), .i_valid(o_out_valid), .i_data(o_out_data),
    .o_ready(i_out_ready), .o_got(got), .o_word(word));
  always #5 i_clk_sys = ~i_clk_sys;
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: value %h, model %h", $time, g, x);
    end
  endtask
  task automatic chk24(input logic [23:0] g, input logic [23:0] x);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected at %0t: sample %h, model %h", $time, g, x);
    end
  endtask
  // one write strobe, released at the next falling edge
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys) {i_reg_addr, i_reg_wdata, i_reg_wr} = {a, d, 1'b1};
    @(negedge i_clk_sys) i_reg_wr = 1'b0;
  endtask
  // read data is registered, so it is looked at one cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    @(negedge i_clk_sys) {i_reg_addr, i_reg_rd} = {a, 1'b1};
    @(negedge i_clk_sys) i_reg_rd = 1'b0;
    chk8(o_reg_rdata, x);
  endtask
  // sample held until ready is high at a rising edge; ready only moves on rising
  // edges, so it is looked at on the falling edge where it is settled
  task automatic snd(input logic [23:0] d, input logic [23:0] x);
    @(negedge i_clk_sys) {i_smp_valid, i_smp_data} = {1'b1, d};
    while (o_smp_ready !== 1'b1) @(negedge i_clk_sys);
    @(posedge i_clk_sys) expq.push_back(x);
    @(negedge i_clk_sys) i_smp_valid = 1'b0;
  endtask
  // every word the sink takes is matched against the model, in order
  always @(posedge i_clk_sys) begin
    cyc++;
    if (got === 1'b1) chk24(word, expq.pop_front());
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(57));
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys) i_sys_rst = 1'b0;
    for (int a = 0; a < 10; a++) begin
      v = $urandom;
      f = a == 0 ? v[7:0] & 8'h04 : a > 5 ? v[7:0] & 8'h7F : v[7:0];
      rdc(a[7:0], 8'h00);
      wrr(a[7:0], v[7:0]);
      rdc(a[7:0], f);
    end
    wrr(8'h0C, 8'hFF);
    rdc(8'h0C, 8'h00);
    rdc(8'h30, 8'h00);
    v = $urandom;
    wrr(8'h04, {2'h3, v[5:0]});
    chk8({o_run, o_recovered_master_clock_oe_n, o_receiver_input_select, o_passthrough_input_select},
      {2'h3, v[5:0]});
    i_lock_lost = 1'b1;
    wrr(8'h01, 8'h82);
    chk8({6'h00, o_clk_from_system, o_recovered_master_clock_half_rate}, 8'h03);
    rdc(8'h0A, i_chan_a_status);
    wrr(8'h01, 8'h01);
    rdc(8'h0A, i_chan_b_status);
    i_buf_xfer_req = 1'b1;
    for (int c = 0; c < 5; c++) begin
      wrr(8'h02, {c[0], c[2:0], 4'h0});
      chk8({5'h00, o_buf_xfer_en, o_deemph_coef}, {5'h00, ~c[0], c[2] ? 2'h2 : c[1:0]});
    end
    i_nonlinear = 1'b1;
    @(negedge i_clk_sys) chk8({6'h00, o_deemph_coef}, 8'h00);
    repeat (8) begin
      v = $urandom;
      f = v[7:0];
      if (!(f[7] && f[5:4] != 2'h3)) f[3] = 1'b0;
      if (f[3]) f[2] = 1'b0;
      wrr(8'h05, v[7:0]);
      chk8(o_ser_fmt, f);
    end
    wrr(8'h05, 8'h00);
    wrr(8'h01, 8'h00);
    wrr(8'h00, 8'h04);
    wrr(8'h02, 8'h10);
    hold = 1'b0;
    v = $urandom;
    snd(v[23:0], v[23:0] & 24'hFFFFF8);
    wrr(8'h02, 8'h00);
    for (int m = 0; m < 5; m++) begin
      wrr(8'h05, {2'h0, m[1:0], 4'h0});
      wrr(8'h01, {1'b0, m == 4, 6'h00});
      repeat (3) begin
        v = $urandom;
        i_smp_raw_blk = v[31];
        e = m == 3 ? {v[23:1], v[31]} : m == 2 ? v[23:0] & 24'hFFFF00 : v[23:0];
        snd(v[23:0], m == 4 ? 24'h000000 : m == 1 ? v[23:0] & 24'hFFFFF0 : e);
      end
      while (expq.size() != 0) @(negedge i_clk_sys);
    end
    // sink stalled: fifo takes exactly four words and then refuses
    hold = 1'b1;
    repeat (4) snd(24'hFFFFFF, 24'h000000);
    chk8({7'h00, o_smp_ready}, 8'h00);
    hold = 1'b0;
    while (expq.size() != 0) @(negedge i_clk_sys);
    wrr(8'h04, 8'h00);
    chk8({7'h00, o_smp_ready}, 8'h00);
    wrr(8'h04, 8'h80);
    wrr(8'h06, 8'h7F);
    wrr(8'h07, 8'h04);
    for (int p = 0; p < 4; p++) begin
      wrr(8'h01, {2'h0, p[1:0], 4'h0});
      i_err_cond = 7'h01;
      @(negedge i_clk_sys) i_err_cond = 7'h00;
      repeat (2) @(negedge i_clk_sys);
      chk8({6'h00, o_int_out, o_int_oe_n}, p == 1 || p == 2 ? 8'h00 : 8'h02);
      chk8({7'h00, o_rx_err_pin}, 8'h01);
      rdc(8'h0C, 8'h01);
      rdc(8'h0C, 8'h00);
      rdc(8'h0D, 8'h04);
      chk8({6'h00, o_int_out, o_int_oe_n}, p == 1 ? 8'h02 : p == 2 ? 8'h03 : 8'h00);
    end
    wrr(8'h06, 8'h7E);
    i_err_cond = 7'h01;
    @(negedge i_clk_sys) i_err_cond = 7'h00;
    rdc(8'h0C, 8'h00);
    // hold policy: a clean sample becomes the last good one, then errored samples
    v = $urandom;
    e = v[23:0];
    snd(e, e);
    for (int h = 0; h < 4; h++) begin
      wrr(8'h01, {4'h0, h[1:0], 2'h0});
      i_err_cond = 7'h02;
      v = $urandom;
      snd(v[23:0], h == 1 ? 24'h000000 : h == 2 ? v[23:0] : e);
      i_err_cond = 7'h00;
    end
    while (expq.size() != 0) @(negedge i_clk_sys);
    // level source survives a read, rising source does not
    wrr(8'h08, 8'h02);
    wrr(8'h09, 8'h00);
    wrr(8'h07, 8'h03);
    i_irq_cond = 7'h03;
    rdc(8'h0D, 8'h03);
    rdc(8'h0D, 8'h02);
    i_irq_cond = 7'h00;
    rdc(8'h0D, 8'h02);
    rdc(8'h0D, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
